// ==== umc_pkg.sv ====
// constants, field layout and carrier types of the modem control and interrupt id block
// Function
// - mcr bit 0 set drives dtr pin low, clear drives it high
// - mcr bit 1 drives the rts pin the same way
// - mcr bit 2 only matters in loopback, feeding the ring status path
// - mcr bit 3 gates the interrupt output; clear keeps it inactive
// - loopback: serial out held marking, serial in ignored, tx shifter feeds rx
// - loopback: modem pins ignored, outputs looped inside, output pins forced high
// - loopback interrupts still work, modem sources from mcr, enables still gate
// - loopback: writing ones to low lsr or msr bits raises interrupts
// - msr change bits set on input change, all cleared by msr read
// - msr bits 0,1,3 flag changes of cts, dsr and dcd
// - msr bit 2 sets only on ring indicator trailing edge
// - any msr change bit set raises a modem status interrupt
// - msr bits 7:4 show inverted pins, or rts,dtr,aux,gate in loopback
// - priority: line status, received data, tx holding empty, modem status
// - iir bit 0 reads 0 while an enabled interrupt pends, else 1
// - iir bits 2:1 encode top source 11,10,01,00; idle reads 001
// - iir bits 7:3 always read zero
// - clears: lsr read, receive buffer read, msr read for their sources
// - tx_holding_empty interrupt clears on iir read reporting it or thr write
// - once iir reports a source, no other is reported until it is serviced
// - ier bits 0..3 enable data, tx_holding_empty, line, modem; bits 7:4 read zero
// - overrun, parity, framing and break flags request the line interrupt
package umc_pkg;

    localparam logic [2:0] OFS_BUFFER = 3'h0;
    localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
    localparam logic [2:0] OFS_INT_ID = 3'h2;
    localparam logic [2:0] OFS_MODEM_CONTROL = 3'h4;
    localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
    localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;

    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_AUX1 = 2;
    localparam int MCR_GATE = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_WIDTH = 5;

    localparam int IER_RXDATA = 0;
    localparam int IER_TX_HOLDING_EMPTY = 1;
    localparam int IER_LINE = 2;
    localparam int IER_MODEM = 3;
    localparam int IER_WIDTH = 4;

    localparam int LSR_DR = 0;
    localparam int LSR_ERR_LO = 1;
    localparam int LSR_ERR_HI = 4;
    localparam int LSR_TX_HOLDING_EMPTY = 5;
    localparam int LSR_TEMT = 6;

    localparam logic [4:0] MCR_RESET = 5'h00;
    localparam logic [3:0] IER_RESET = 4'h0;

    localparam logic [2:0] IID_NONE = 3'h1;
    localparam logic [2:0] IID_LINE = 3'h6;
    localparam logic [2:0] IID_RXDATA = 3'h4;
    localparam logic [2:0] IID_TX_HOLDING_EMPTY = 3'h2;
    localparam logic [2:0] IID_MODEM = 3'h0;

    // bit order matches msr bits 3:0 and 7:4
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } umc_modem_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wrData;
    } umc_host_req_type;

    // bit order matches lsr bits 4:1
    typedef struct packed {
        logic brk;
        logic framing;
        logic parity;
        logic overrun;
    } umc_line_err_type;

    typedef enum logic [1:0] {
        UMC_ID_FREE = 2'b01,
        UMC_ID_HELD = 2'b10
    } umc_id_state_type;

endpackage : umc_pkg

// ==== umc_sync.sv ====
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
module umc_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    input wire logic mclk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;

    // pins idle high, so reset to the inactive level avoids false change flags
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            stage1_q <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            stage1_q <= asyncIn;
            syncOut <= stage1_q;
        end
    end

endmodule : umc_sync

// ==== umc_modem_ctl.sv ====
// modem control, modem status, loopback and interrupt identification logic
`timescale 1ns/100ps
module umc_modem_ctl (
    input wire logic mclk,
    input wire logic nrst,
    input wire umc_pkg::umc_host_req_type hostReq,
    input wire logic dlab,
    output logic [7:0] rdData,
    input wire umc_pkg::umc_modem_type modemInN,
    input wire logic serialIn,
    output logic dtrN,
    output logic rtsN,
    output logic serialOut,
    input wire logic txShiftOut,
    output logic rxShiftIn,
    input wire logic rxDataReady,
    input wire umc_pkg::umc_line_err_type lineErrSet,
    input wire logic txHoldEmpty,
    input wire logic txEmpty,
    output logic interruptOut
);

    logic [1:0] rstSync_q;
    logic rstN;
    logic [4:0] pinSync;
    umc_pkg::umc_modem_type modemPin;
    logic serialInSync;

    logic [umc_pkg::MCR_WIDTH-1:0] mcr_q;
    logic [umc_pkg::IER_WIDTH-1:0] ier_q;
    umc_pkg::umc_modem_type modemLive;
    umc_pkg::umc_modem_type modemPrev_q;
    umc_pkg::umc_modem_type msrDelta_q;
    umc_pkg::umc_line_err_type lineErr_q;
    logic drForce_q;
    logic threForce_q;
    logic threPrev_q;
    logic threInt_q;
    umc_pkg::umc_id_state_type idState_q;
    logic [2:0] heldCode_q;

    logic loopback;
    logic rdStrobe;
    logic wrStrobe;
    logic bufRead;
    logic thrWrite;
    logic iirRead;
    logic lsrRead;
    logic msrRead;
    logic lsrWrite;
    logic msrWrite;
    logic dataReady;
    logic thrEmpty;
    logic pendLine;
    logic pendRxData;
    logic pendThre;
    logic pendModem;
    logic [2:0] topCode;
    logic [2:0] idCode;
    logic [7:0] readValue;

    // reset is taken asynchronously and released through two flip-flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    assign rstN = rstSync_q[1];

    umc_sync #(
        .WIDTH(5),
        .RESET_VALUE(5'h1F)
    ) pinSyncInst (
        .mclk(mclk),
        .rstN(rstN),
        .asyncIn({serialIn, modemInN}),
        .syncOut(pinSync)
    );

    assign serialInSync = pinSync[4];
    assign modemPin = umc_pkg::umc_modem_type'(~pinSync[3:0]);

    // priority encoder for the live path; the held path is checked by stillPending
    function automatic logic [2:0] prioCode(
        input logic line,
        input logic rxd,
        input logic tx_holding_empty,
        input logic modem
    );
        logic [2:0] code;
        code = umc_pkg::IID_NONE;
        if (line) begin
            code = umc_pkg::IID_LINE;
        end else if (rxd) begin
            code = umc_pkg::IID_RXDATA;
        end else if (tx_holding_empty) begin
            code = umc_pkg::IID_TX_HOLDING_EMPTY;
        end else if (modem) begin
            code = umc_pkg::IID_MODEM;
        end
        return code;
    endfunction : prioCode

    function automatic logic stillPending(
        input logic [2:0] code,
        input logic line,
        input logic rxd,
        input logic tx_holding_empty,
        input logic modem
    );
        logic hit;
        hit = 1'b0;
        case (code)
            umc_pkg::IID_LINE: hit = line;
            umc_pkg::IID_RXDATA: hit = rxd;
            umc_pkg::IID_TX_HOLDING_EMPTY: hit = tx_holding_empty;
            umc_pkg::IID_MODEM: hit = modem;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : stillPending

    assign loopback = mcr_q[umc_pkg::MCR_LOOP];
    assign rdStrobe = hostReq.rd;
    assign wrStrobe = hostReq.wr;
    assign bufRead = rdStrobe && !dlab && hostReq.addr == umc_pkg::OFS_BUFFER;
    assign thrWrite = wrStrobe && !dlab && hostReq.addr == umc_pkg::OFS_BUFFER;
    assign iirRead = rdStrobe && hostReq.addr == umc_pkg::OFS_INT_ID;
    assign lsrRead = rdStrobe && hostReq.addr == umc_pkg::OFS_LINE_STATUS;
    assign msrRead = rdStrobe && hostReq.addr == umc_pkg::OFS_MODEM_STATUS;
    assign lsrWrite = wrStrobe && loopback && hostReq.addr == umc_pkg::OFS_LINE_STATUS;
    assign msrWrite = wrStrobe && loopback && hostReq.addr == umc_pkg::OFS_MODEM_STATUS;

    // in loopback the modem inputs see the control outputs instead of the pins
    always_comb begin
        if (loopback) begin
            modemLive.cts = mcr_q[umc_pkg::MCR_RTS];
            modemLive.dsr = mcr_q[umc_pkg::MCR_DTR];
            modemLive.ri = mcr_q[umc_pkg::MCR_AUX1];
            modemLive.dcd = mcr_q[umc_pkg::MCR_GATE];
        end else begin
            modemLive = modemPin;
        end
    end

    // control registers
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            mcr_q <= umc_pkg::MCR_RESET;
        end else if (wrStrobe && hostReq.addr == umc_pkg::OFS_MODEM_CONTROL) begin
            mcr_q <= hostReq.wrData[umc_pkg::MCR_WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            ier_q <= umc_pkg::IER_RESET;
        end else if (wrStrobe && !dlab && hostReq.addr == umc_pkg::OFS_INT_ENABLE) begin
            ier_q <= hostReq.wrData[umc_pkg::IER_WIDTH-1:0];
        end
    end

    // modem change detection; a new change beats a simultaneous read clear
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            modemPrev_q <= '0;
        end else begin
            modemPrev_q <= modemLive;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            msrDelta_q <= '0;
        end else begin
            if (msrRead) begin
                msrDelta_q <= '0;
            end
            if (modemLive.cts != modemPrev_q.cts
                    || (msrWrite && hostReq.wrData[0])) begin
                msrDelta_q.cts <= 1'b1;
            end
            if (modemLive.dsr != modemPrev_q.dsr
                    || (msrWrite && hostReq.wrData[1])) begin
                msrDelta_q.dsr <= 1'b1;
            end
            if ((modemPrev_q.ri && !modemLive.ri)
                    || (msrWrite && hostReq.wrData[2])) begin
                msrDelta_q.ri <= 1'b1;
            end
            if (modemLive.dcd != modemPrev_q.dcd
                    || (msrWrite && hostReq.wrData[3])) begin
                msrDelta_q.dcd <= 1'b1;
            end
        end
    end

    // line error flags, sticky until the line status read
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            lineErr_q <= '0;
        end else begin
            lineErr_q <= (lsrRead ? 4'h0 : lineErr_q) | lineErrSet
                | (lsrWrite ? hostReq.wrData[umc_pkg::LSR_ERR_HI:umc_pkg::LSR_ERR_LO] : 4'h0);
        end
    end

    // test-forced data ready and holding-empty bits, only reachable in loopback
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            drForce_q <= 1'b0;
        end else if (lsrWrite && hostReq.wrData[umc_pkg::LSR_DR]) begin
            drForce_q <= 1'b1;
        end else if (bufRead) begin
            drForce_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            threForce_q <= 1'b0;
        end else if (lsrWrite && hostReq.wrData[umc_pkg::LSR_TX_HOLDING_EMPTY]) begin
            threForce_q <= 1'b1;
        end else if (thrWrite) begin
            threForce_q <= 1'b0;
        end
    end

    assign dataReady = rxDataReady || drForce_q;
    assign thrEmpty = txHoldEmpty || threForce_q;

    // holding-empty interrupt is an event latched on the empty edge
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            threPrev_q <= 1'b0;
        end else begin
            threPrev_q <= thrEmpty;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            threInt_q <= 1'b0;
        end else if (thrEmpty && !threPrev_q) begin
            threInt_q <= 1'b1;
        end else if (thrWrite || (iirRead && idCode == umc_pkg::IID_TX_HOLDING_EMPTY)) begin
            threInt_q <= 1'b0;
        end
    end

    assign pendLine = ier_q[umc_pkg::IER_LINE] && |lineErr_q;
    assign pendRxData = ier_q[umc_pkg::IER_RXDATA] && dataReady;
    assign pendThre = ier_q[umc_pkg::IER_TX_HOLDING_EMPTY] && threInt_q;
    assign pendModem = ier_q[umc_pkg::IER_MODEM] && |msrDelta_q;

    assign topCode = prioCode(pendLine, pendRxData, pendThre, pendModem);

    // a reported source stays reported until it is serviced
    assign idCode = (idState_q == umc_pkg::UMC_ID_HELD
            && stillPending(heldCode_q, pendLine, pendRxData, pendThre, pendModem))
        ? heldCode_q : topCode;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            idState_q <= umc_pkg::UMC_ID_FREE;
            heldCode_q <= umc_pkg::IID_NONE;
        end else begin
            case (idState_q)
                umc_pkg::UMC_ID_FREE: begin
                    if (iirRead && idCode != umc_pkg::IID_NONE
                            && idCode != umc_pkg::IID_TX_HOLDING_EMPTY) begin
                        idState_q <= umc_pkg::UMC_ID_HELD;
                        heldCode_q <= idCode;
                    end
                end
                umc_pkg::UMC_ID_HELD: begin
                    if (!stillPending(heldCode_q, pendLine, pendRxData, pendThre, pendModem)) begin
                        idState_q <= umc_pkg::UMC_ID_FREE;
                        heldCode_q <= umc_pkg::IID_NONE;
                    end
                end
                default: begin
                    idState_q <= umc_pkg::UMC_ID_FREE;
                    heldCode_q <= umc_pkg::IID_NONE;
                end
            endcase
        end
    end

    // read mux; unmapped or foreign offsets read zero
    always_comb begin
        readValue = 8'h00;
        case (hostReq.addr)
            umc_pkg::OFS_INT_ENABLE: begin
                if (!dlab) begin
                    readValue = {4'h0, ier_q};
                end
            end
            umc_pkg::OFS_INT_ID: begin
                readValue = {5'h00, idCode};
            end
            umc_pkg::OFS_MODEM_CONTROL: begin
                readValue = {3'h0, mcr_q};
            end
            umc_pkg::OFS_LINE_STATUS: begin
                readValue = {1'b0, txEmpty, thrEmpty, lineErr_q, dataReady};
            end
            umc_pkg::OFS_MODEM_STATUS: begin
                readValue = {modemLive, msrDelta_q};
            end
            default: begin
                readValue = 8'h00;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rdData <= 8'h00;
        end else if (rdStrobe) begin
            rdData <= readValue;
        end
    end

    // pins: outputs are active low and parked high in loopback
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            dtrN <= 1'b1;
            rtsN <= 1'b1;
        end else begin
            dtrN <= loopback || !mcr_q[umc_pkg::MCR_DTR];
            rtsN <= loopback || !mcr_q[umc_pkg::MCR_RTS];
        end
    end

    // serial path; loopback costs one cycle of delay on the looped data
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            serialOut <= 1'b1;
            rxShiftIn <= 1'b1;
        end else begin
            serialOut <= loopback ? 1'b1 : txShiftOut;
            rxShiftIn <= loopback ? txShiftOut : serialInSync;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            interruptOut <= 1'b0;
        end else begin
            interruptOut <= idCode != umc_pkg::IID_NONE && mcr_q[umc_pkg::MCR_GATE];
        end
    end

endmodule : umc_modem_ctl

// ==== umc_modem_ctl_props.sv ====
// concurrent checks on the ports of the modem control and interrupt id block
`timescale 1ns/100ps
module umc_modem_ctl_props (
    input wire logic mclk,
    input wire logic nrst,
    input wire umc_pkg::umc_host_req_type hostReq,
    input wire logic dlab,
    input wire logic [7:0] rdData,
    input wire logic dtrN,
    input wire logic rtsN,
    input wire logic serialOut,
    input wire logic txShiftOut,
    input wire logic rxShiftIn,
    input wire logic interruptOut
);
    logic [4:0] mcrQ;
    logic [2:0] ageQ;
    logic [2:0] liveQ;
    // mirror of the control register, so pin levels can be tied to the last write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mcrQ <= 5'h00;
        end else if (hostReq.wr && hostReq.addr == 3'h4) begin
            mcrQ <= hostReq.wrData[4:0];
        end
    end
    // loop paths settle a few cycles after a write, so loop status checks wait for age 7
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ageQ <= 3'h0;
        end else if (hostReq.wr && hostReq.addr == 3'h4) begin
            ageQ <= 3'h0;
        end else if (ageQ != 3'h7) begin
            ageQ <= ageQ + 3'h1;
        end
    end
    // internal reset copy releases three edges late, one edge after the block's own
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            liveQ <= 3'h0;
        end else begin
            liveQ <= {liveQ[1:0], 1'b1};
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    AST_DTR_LEVEL: assert property (liveQ[2] |-> dtrN == ($past(mcrQ[4]) || !$past(mcrQ[0])))
        else $error("dtr pin does not follow control bit 0");
    AST_RTS_LEVEL: assert property (liveQ[2] |-> rtsN == ($past(mcrQ[4]) || !$past(mcrQ[1])))
        else $error("rts pin does not follow control bit 1");
    AST_SEROUT: assert property (liveQ[2] |-> serialOut == ($past(mcrQ[4]) || $past(txShiftOut)))
        else $error("serial out not marking in loopback or not following shifter");
    AST_LOOP_RX: assert property (liveQ[2] && $past(mcrQ[4]) |-> rxShiftIn == $past(txShiftOut))
        else $error("receive input not fed from transmit shifter in loopback");
    AST_LOOP_PINS: assert property (liveQ[2] && $rose(mcrQ[4]) |=> (dtrN && rtsN) [*2])
        else $error("modem output pins not forced inactive in loopback");
    AST_GATE_OFF: assert property (liveQ[2] && !$past(mcrQ[3]) |-> !interruptOut)
        else $error("interrupt pin active while gate bit is clear");
    AST_IIR_FORMAT: assert property (hostReq.rd && hostReq.addr == 3'h2 ##1 !hostReq.rd
        |-> ##1 rdData[7:3] == 5'h00 && (!rdData[0] || rdData[2:1] == 2'b00))
        else $error("identification read has bad format");
    AST_IER_HIGH: assert property (hostReq.rd && hostReq.addr == 3'h1 && !dlab ##1 !hostReq.rd
        |-> ##1 rdData[7:4] == 4'h0)
        else $error("enable register upper bits not zero");
    AST_LOOP_MSR: assert property (hostReq.rd && hostReq.addr == 3'h6 && mcrQ[4] && ageQ == 3'h7
        ##1 !hostReq.rd |-> ##1 rdData[7:4] ==
        {$past(mcrQ[3], 2), $past(mcrQ[2], 2), $past(mcrQ[0], 2), $past(mcrQ[1], 2)})
        else $error("loopback status bits do not show control outputs");
endmodule : umc_modem_ctl_props

bind umc_modem_ctl umc_modem_ctl_props umc_modem_ctl_props_inst (.mclk(mclk), .nrst(nrst),
    .hostReq(hostReq), .dlab(dlab), .rdData(rdData), .dtrN(dtrN), .rtsN(rtsN),
    .serialOut(serialOut), .txShiftOut(txShiftOut), .rxShiftIn(rxShiftIn),
    .interruptOut(interruptOut));

// ==== umc_modem_model.sv ====
// data set model on the modem handshake pins
`timescale 1ns/100ps
module umc_modem_model (
    input wire logic mclk,
    input wire logic dtrN,
    input wire logic rtsN,
    input wire logic ringOn,
    input wire logic carrierOn,
    input wire logic slowAns,
    output umc_pkg::umc_modem_type modemInN
);
    logic [7:0] rtsHist = 8'hFF;
    logic [7:0] dtrHist = 8'hFF;
    always @(posedge mclk) begin
        rtsHist <= {rtsHist[6:0], rtsN};
        dtrHist <= {dtrHist[6:0], dtrN};
    end
    // answers the requests after a short or a long turnaround
    assign modemInN = {~carrierOn, ~ringOn, slowAns ? dtrHist[7] : dtrHist[0],
        slowAns ? rtsHist[7] : rtsHist[0]};
endmodule : umc_modem_model

// ==== tb_top.sv ====
// self-checking testbench of the modem control and interrupt id block
`timescale 1ns/100ps
module tb_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    umc_pkg::umc_host_req_type hostReq = '0;
    logic dlab = 1'b0;
    logic [7:0] rdData;
    umc_pkg::umc_modem_type modemInN;
    logic serialIn = 1'b1;
    logic dtrN;
    logic rtsN;
    logic serialOut;
    logic txShiftOut = 1'b1;
    logic rxShiftIn;
    logic rxDataReady = 1'b0;
    umc_pkg::umc_line_err_type lineErrSet = '0;
    logic txHoldEmpty = 1'b0;
    logic txEmpty = 1'b0;
    logic interruptOut;
    logic ringOn = 1'b0;
    logic carrierOn = 1'b0;
    logic slowAns = 1'b0;
    logic [7:0] got;
    int fails = 0;
    int n_checks = 0;

    always #5 mclk = ~mclk;

    umc_modem_ctl umc_modem_ctl_inst (.mclk(mclk), .nrst(nrst), .hostReq(hostReq), .dlab(dlab),
        .rdData(rdData), .modemInN(modemInN), .serialIn(serialIn), .dtrN(dtrN), .rtsN(rtsN),
        .serialOut(serialOut), .txShiftOut(txShiftOut), .rxShiftIn(rxShiftIn),
        .rxDataReady(rxDataReady), .lineErrSet(lineErrSet), .txHoldEmpty(txHoldEmpty),
        .txEmpty(txEmpty), .interruptOut(interruptOut));
    umc_modem_model umc_modem_model_inst (.mclk(mclk), .dtrN(dtrN), .rtsN(rtsN),
        .ringOn(ringOn), .carrierOn(carrierOn), .slowAns(slowAns), .modemInN(modemInN));

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t byte %h expected %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t pin %b expected %b", $time, g, e);
        end
    endtask : chk1
    task automatic regWr(input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk);
        hostReq = '{1'b0, 1'b1, a, d};
        @(negedge mclk);
        hostReq.wr = 1'b0;
    endtask : regWr
    task automatic rdChk(input logic [2:0] a, input logic [7:0] e);
        @(negedge mclk);
        hostReq = '{1'b1, 1'b0, a, 8'h00};
        @(negedge mclk);
        hostReq.rd = 1'b0;
        @(negedge mclk);
        chk8(rdData, e);
    endtask : rdChk

    task automatic t_reset;
        rdChk(3'h2, 8'h01);
        rdChk(3'h6, 8'h00);
        rdChk(3'h7, 8'h00);
        chk1(dtrN, 1'b1);
        chk1(interruptOut, 1'b0);
    endtask : t_reset
    task automatic t_modem;
        slowAns = 1'b1;
        regWr(3'h4, 8'h03);
        tick(2);
        chk1(dtrN, 1'b0);
        chk1(rtsN, 1'b0);
        tick(16);
        rdChk(3'h4, 8'h03);
        rdChk(3'h6, 8'h33);
        rdChk(3'h6, 8'h30);
        slowAns = 1'b0;
    endtask : t_modem
    task automatic t_ring;
        ringOn = 1'b1;
        tick(6);
        rdChk(3'h6, 8'h70);
        ringOn = 1'b0;
        tick(6);
        rdChk(3'h6, 8'h34);
        carrierOn = 1'b1;
        tick(6);
        rdChk(3'h6, 8'hB8);
        rdChk(3'h6, 8'hB0);
    endtask : t_ring
    task automatic t_prio;
        regWr(3'h1, 8'hFF);
        rdChk(3'h1, 8'h0F);
        dlab = 1'b1;
        regWr(3'h1, 8'h00);
        dlab = 1'b0;
        rdChk(3'h1, 8'h0F);
        regWr(3'h4, 8'h0B);
        carrierOn = 1'b0;
        tick(6);
        rdChk(3'h2, 8'h00);
        chk1(interruptOut, 1'b1);
        rxDataReady = 1'b1;
        tick(2);
        rdChk(3'h2, 8'h00);
        rdChk(3'h6, 8'h38);
        rdChk(3'h2, 8'h04);
        rxDataReady = 1'b0;
        txHoldEmpty = 1'b1;
        lineErrSet.parity = 1'b1;
        tick(1);
        lineErrSet = '0;
        tick(2);
        rdChk(3'h2, 8'h06);
        rdChk(3'h5, 8'h24);
        rdChk(3'h2, 8'h02);
        rdChk(3'h2, 8'h01);
        chk1(interruptOut, 1'b0);
        txHoldEmpty = 1'b0;
        tick(2);
        txHoldEmpty = 1'b1;
        tick(3);
        chk1(interruptOut, 1'b1);
        regWr(3'h4, 8'h03);
        tick(2);
        chk1(interruptOut, 1'b0);
        regWr(3'h0, 8'h55);
        rdChk(3'h2, 8'h01);
    endtask : t_prio
    task automatic t_loop;
        regWr(3'h1, 8'h08);
        regWr(3'h4, 8'h1F);
        txShiftOut = 1'b0;
        txEmpty = 1'b1;
        tick(9);
        chk1(dtrN & rtsN & serialOut, 1'b1);
        chk1(rxShiftIn, 1'b0);
        rdChk(3'h6, 8'hF8);
        rdChk(3'h6, 8'hF0);
        regWr(3'h4, 8'h1B);
        tick(8);
        chk1(interruptOut, 1'b1);
        rdChk(3'h6, 8'hB4);
        regWr(3'h1, 8'h0C);
        regWr(3'h5, 8'h02);
        regWr(3'h6, 8'h01);
        tick(2);
        rdChk(3'h2, 8'h06);
        rdChk(3'h5, 8'h62);
        rdChk(3'h2, 8'h00);
        rdChk(3'h6, 8'hB1);
        rdChk(3'h2, 8'h01);
        regWr(3'h1, 8'h01);
        regWr(3'h5, 8'h01);
        rdChk(3'h2, 8'h04);
        rdChk(3'h0, 8'h00);
        rdChk(3'h2, 8'h01);
        regWr(3'h1, 8'h00);
        regWr(3'h4, 8'h00);
        tick(2);
        chk1(serialOut, 1'b0);
        chk1(rxShiftIn, 1'b1);
        serialIn = 1'b0;
        tick(4);
        chk1(rxShiftIn, 1'b0);
        serialIn = 1'b1;
        txShiftOut = 1'b1;
    endtask : t_loop

    task automatic test_done;
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (4) @(negedge mclk);
        nrst = 1'b1;
        tick(3);
        t_reset();
        t_modem();
        t_ring();
        t_prio();
        t_loop();
        test_done();
    end
    // the sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        test_done();
    end
endmodule : tb_top
